//--- src/mdf_filter.sv
// Multidrop address filter with radio keying and AXI4-Lite registers
// Contract
// - One master; slave never transmits unsolicited
// - Point-to-point peer: either side may start
// - Idle slave tracks line busy or idle
// - Break-attach: after idle, hunt for break
// - After break, hunt for attach request
// - Answer attach only on own station identifier
// - Enquiry protocol: after idle, hunt enquiries
// - Accept only enquiries with own processor identifier
// - Station protocol: own or broadcast address only
// - Key radio, wait warm-up, then send
// - Timeouts lengthened by keying delay
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
module mdf_filter
  import mdf_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int BIT_CYCLES = 1085,
  parameter int IDLE_BITS = 11,
  parameter int BREAK_BITS = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_pin,
  input wire mdf_byte_t rx_byte,
  output mdf_byte_t acc_byte,
  output logic acc_start,
  output logic acc_bcast,
  input wire logic tx_req,
  output logic tx_ready,
  output logic radio_key,
  output logic [16:0] eff_timeout
);

  initial begin
    if (ADDR_W < 5 || ADDR_W > 32) begin
      $error("mdf_filter: ADDR_W out of range");
    end
  end

  typedef enum logic [2:0] {
    RX_OFF, RX_WAIT_IDLE, RX_HUNT, RX_ATTACH, RX_ENQ_ID,
    RX_SELECTED, RX_IGNORE
  } mdf_rx_state_t;

  typedef enum logic [1:0] {TX_IDLE, TX_WARM, TX_SEND} mdf_tx_state_t;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(off[7:2]));
  endfunction : hit

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // Configuration and bus state
  mdf_cfg_t cfg_q;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // Filter and transmit state
  mdf_rx_state_t rx_q, rx_d;
  mdf_tx_state_t tx_q, tx_d;
  logic bcast_q, bcast_d;
  logic start_q;
  mdf_byte_t acc_q;
  logic [15:0] warm_q;
  logic key_q;
  logic [16:0] eff_q;

  logic rx_level, line_idle, break_pulse;
  logic idle_prev_q;

  mdf_line_mon #(
    .BIT_CYCLES(BIT_CYCLES),
    .IDLE_BITS(IDLE_BITS),
    .BREAK_BITS(BREAK_BITS)
  ) u_mon (
    .aclk(aclk),
    .aresetn(aresetn),
    .rx_pin(rx_pin),
    .rx_level(rx_level),
    .line_idle(line_idle),
    .break_pulse(break_pulse)
  );

  // AXI4-Lite write path: address and data may arrive in either order
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  wire do_write = aw_hold_q && w_hold_q && !bvalid_q;
  wire wr_ctrl = do_write && hit(awaddr_q, OFF_CTRL);
  wire wr_id = do_write && hit(awaddr_q, OFF_OWN_ID);
  wire wr_kd = do_write && hit(awaddr_q, OFF_KEY_DLY);
  wire wr_tb = do_write && hit(awaddr_q, OFF_TMO_BASE);
  wire wr_ro = hit(awaddr_q, OFF_STATUS) || hit(awaddr_q, OFF_EFF_TMO);
  wire wr_ok = wr_ctrl || wr_id || wr_kd || wr_tb || wr_ro;
  // Settings only change while the filter is stopped
  wire cfg_open = !cfg_q.en;

  wire [31:0] ctrl_rd = {26'h0, cfg_q.proto, cfg_q.radio, cfg_q.peer,
                         cfg_q.master, cfg_q.en};
  wire [31:0] ctrl_new = merge(ctrl_rd, wdata_q, wstrb_q);
  wire [31:0] id_new = merge({24'h0, cfg_q.own_id}, wdata_q, wstrb_q);
  wire [31:0] kd_new = merge({16'h0, cfg_q.key_dly}, wdata_q, wstrb_q);
  wire [31:0] tb_new = merge({16'h0, cfg_q.tmo_base}, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= '{en: 1'b0, master: 1'b0, peer: 1'b0, radio: 1'b0,
                 proto: PROTO_BREAK_ATTACH, own_id: RST_OWN_ID,
                 key_dly: RST_KEY_DLY, tmo_base: RST_TMO_BASE};
    end else begin
      if (wr_ctrl) begin
        cfg_q.en <= ctrl_new[CTRL_EN];
        if (cfg_open) begin
          cfg_q.master <= ctrl_new[CTRL_MASTER];
          cfg_q.peer <= ctrl_new[CTRL_PEER];
          cfg_q.radio <= ctrl_new[CTRL_RADIO];
          cfg_q.proto <= ctrl_new[CTRL_PROTO_HI:CTRL_PROTO_LO];
        end
      end
      if (wr_id && cfg_open) begin
        cfg_q.own_id <= id_new[7:0];
      end
      if (wr_kd && cfg_open) begin
        cfg_q.key_dly <= kd_new[15:0];
      end
      if (wr_tb && cfg_open) begin
        cfg_q.tmo_base <= tb_new[15:0];
      end
    end
  end

  // AXI4-Lite read path: one outstanding read, answer one cycle later
  wire [31:0] stat_rd = {26'h0, rx_level, tx_ready, key_q, bcast_q,
                         (rx_q == RX_SELECTED), line_idle};
  wire rd_ctrl = hit(s_axi_araddr, OFF_CTRL);
  wire rd_id = hit(s_axi_araddr, OFF_OWN_ID);
  wire rd_kd = hit(s_axi_araddr, OFF_KEY_DLY);
  wire rd_tb = hit(s_axi_araddr, OFF_TMO_BASE);
  wire rd_st = hit(s_axi_araddr, OFF_STATUS);
  wire rd_et = hit(s_axi_araddr, OFF_EFF_TMO);
  wire rd_ok = rd_ctrl || rd_id || rd_kd || rd_tb || rd_st || rd_et;
  wire [31:0] rd_mux =
    rd_ctrl ? ctrl_rd :
    rd_id ? {24'h0, cfg_q.own_id} :
    rd_kd ? {16'h0, cfg_q.key_dly} :
    rd_tb ? {16'h0, cfg_q.tmo_base} :
    rd_st ? stat_rd :
    rd_et ? {15'h0, eff_q} : 32'h0000_0000;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Address filter
  wire idle_rise = line_idle && !idle_prev_q;
  wire rxv = rx_byte.valid;
  wire own = (rx_byte.data == cfg_q.own_id);
  wire is_bc = (rx_byte.data == BCAST_ADDR);

  always_comb begin
    rx_d = rx_q;
    bcast_d = bcast_q;
    unique case (rx_q)
      RX_OFF: begin
        if (cfg_q.en && !cfg_q.master) begin
          rx_d = RX_WAIT_IDLE;
        end
      end
      RX_WAIT_IDLE: begin
        if (line_idle) begin
          rx_d = RX_HUNT;
        end
      end
      RX_HUNT: begin
        bcast_d = 1'b0;
        if (cfg_q.proto == PROTO_BREAK_ATTACH) begin
          if (break_pulse) begin
            rx_d = RX_ATTACH;
          end
        end else if (cfg_q.proto == PROTO_ENQUIRY) begin
          if (rxv) begin
            rx_d = (rx_byte.data == ENQ_MARK) ? RX_ENQ_ID : RX_IGNORE;
          end
        end else if (rxv) begin
          rx_d = (own || is_bc) ? RX_SELECTED : RX_IGNORE;
          bcast_d = is_bc && !own;
        end
      end
      RX_ATTACH: begin
        if (rxv) begin
          rx_d = own ? RX_SELECTED : RX_IGNORE;
        end
      end
      RX_ENQ_ID: begin
        if (rxv) begin
          rx_d = own ? RX_SELECTED : RX_IGNORE;
        end
      end
      RX_SELECTED, RX_IGNORE: begin
        if (idle_rise) begin
          rx_d = RX_HUNT;
        end
      end
      default: rx_d = RX_OFF;
    endcase
    if (!cfg_q.en || cfg_q.master) begin
      rx_d = RX_OFF;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_q <= RX_OFF;
      bcast_q <= 1'b0;
      idle_prev_q <= 1'b0;
      start_q <= 1'b0;
      acc_q <= '0;
    end else begin
      rx_q <= rx_d;
      bcast_q <= bcast_d;
      idle_prev_q <= line_idle;
      start_q <= (rx_d == RX_SELECTED) && (rx_q != RX_SELECTED);
      // Selected slaves, and a master, see the message bytes
      acc_q.valid <= rxv && cfg_q.en &&
                     (cfg_q.master || rx_q == RX_SELECTED);
      acc_q.data <= rx_byte.data;
    end
  end

  assign acc_byte = acc_q;
  assign acc_start = start_q;
  assign acc_bcast = bcast_q;

  // Transmit permission and radio keying
  wire sel_reply = (rx_q == RX_SELECTED) && !bcast_q;
  wire tx_allow = cfg_q.en &&
                  (cfg_q.master || cfg_q.peer || sel_reply);

  always_comb begin
    tx_d = tx_q;
    unique case (tx_q)
      TX_IDLE: begin
        if (tx_req && tx_allow) begin
          tx_d = cfg_q.radio ? TX_WARM : TX_SEND;
        end
      end
      TX_WARM: begin
        if (!tx_req) begin
          tx_d = TX_IDLE;
        end else if (warm_q == 16'h0000) begin
          tx_d = TX_SEND;
        end
      end
      TX_SEND: begin
        if (!tx_req) begin
          tx_d = TX_IDLE;
        end
      end
      default: tx_d = TX_IDLE;
    endcase
    if (!cfg_q.en) begin
      tx_d = TX_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_q <= TX_IDLE;
      warm_q <= 16'h0000;
      key_q <= 1'b0;
      eff_q <= 17'h0_0000;
    end else begin
      tx_q <= tx_d;
      if (tx_q == TX_IDLE) begin
        warm_q <= cfg_q.key_dly;
      end else if (warm_q != 16'h0000) begin
        warm_q <= warm_q - 16'h0001;
      end
      key_q <= cfg_q.radio && (tx_d != TX_IDLE);
      // With radio keying on, the timeout carries the keying delay key_dly
      eff_q <= {1'b0, cfg_q.tmo_base} +
               {1'b0, cfg_q.radio ? cfg_q.key_dly : 16'h0000};
    end
  end

  assign tx_ready = (tx_q == TX_SEND);
  assign radio_key = key_q;
  assign eff_timeout = eff_q;

endmodule : mdf_filter

//--- src/mdf_pkg.sv
// Shared constants and types for the multidrop address filter
package mdf_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OWN_ID = 8'h04;
  localparam logic [7:0] OFF_KEY_DLY = 8'h08;
  localparam logic [7:0] OFF_TMO_BASE = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_EFF_TMO = 8'h14;

  // Control register field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_PEER = 2;
  localparam int CTRL_RADIO = 3;
  localparam int CTRL_PROTO_LO = 4;
  localparam int CTRL_PROTO_HI = 5;

  // Status register field positions
  localparam int STAT_IDLE = 0;
  localparam int STAT_SEL = 1;
  localparam int STAT_BCAST = 2;
  localparam int STAT_KEY = 3;
  localparam int STAT_TXRDY = 4;
  localparam int STAT_RXLVL = 5;

  // Protocol selection codes
  localparam logic [1:0] PROTO_BREAK_ATTACH = 2'h0;
  localparam logic [1:0] PROTO_ENQUIRY = 2'h1;
  localparam logic [1:0] PROTO_STATION = 2'h2;

  // Message markers
  localparam logic [7:0] ENQ_MARK = 8'h05;
  localparam logic [7:0] BCAST_ADDR = 8'h00;

  // Reset values
  localparam logic [7:0] RST_OWN_ID = 8'h01;
  localparam logic [15:0] RST_KEY_DLY = 16'h0000;
  localparam logic [15:0] RST_TMO_BASE = 16'h0100;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic en;
    logic master;
    logic peer;
    logic radio;
    logic [1:0] proto;
    logic [7:0] own_id;
    logic [15:0] key_dly;
    logic [15:0] tmo_base;
  } mdf_cfg_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mdf_byte_t;

endpackage : mdf_pkg

//--- src/mdf_line_mon.sv
// Line activity monitor: pin synchroniser, idle and break detection
`timescale 1ns/10ps
module mdf_line_mon
  import mdf_pkg::*;
#(
  parameter int BIT_CYCLES = 1085,
  parameter int IDLE_BITS = 11,
  parameter int BREAK_BITS = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_pin,
  output logic rx_level,
  output logic line_idle,
  output logic break_pulse
);

  initial begin
    if (BIT_CYCLES < 2 || IDLE_BITS < 1 || BREAK_BITS < 2 ||
        IDLE_BITS > 255 || BREAK_BITS > 255) begin
      $error("mdf_line_mon: unsupported parameter value");
    end
  end

  localparam int DW = $clog2(BIT_CYCLES);
  localparam logic [DW-1:0] DIV_LAST = DW'(BIT_CYCLES - 1);
  localparam logic [7:0] IDLE_CNT = 8'(IDLE_BITS);
  localparam logic [7:0] BREAK_CNT = 8'(BREAK_BITS);

  logic sync1_q, sync2_q, lvl_q;
  logic [DW-1:0] div_q;
  logic [7:0] run_q;
  logic idle_q, brk_q;

  wire bit_tick = (div_q == DIV_LAST);
  wire edge_seen = (sync2_q != lvl_q);
  wire run_full = (run_q == 8'hFF);

  // Bit-time enable; run length restarts on every level change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      lvl_q <= 1'b1;
      div_q <= '0;
      run_q <= 8'h00;
    end else begin
      sync1_q <= rx_pin;
      sync2_q <= sync1_q;
      lvl_q <= sync2_q;
      div_q <= (bit_tick || edge_seen) ? '0 : div_q + DW'(1);
      if (edge_seen) begin
        run_q <= 8'h00;
      end else if (bit_tick && !run_full) begin
        run_q <= run_q + 8'h01;
      end
    end
  end

  // Idle after a run of marks; one break pulse per long space
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_q <= 1'b0;
      brk_q <= 1'b0;
      break_pulse <= 1'b0;
    end else begin
      idle_q <= lvl_q && (run_q >= IDLE_CNT);
      break_pulse <= !lvl_q && (run_q >= BREAK_CNT) && !brk_q;
      brk_q <= !lvl_q && (run_q >= BREAK_CNT);
    end
  end

  assign rx_level = lvl_q;
  assign line_idle = idle_q;

endmodule : mdf_line_mon

//--- sim/mdf_filter_assertions.sv
// Port-level temporal checks for the multidrop address filter
`timescale 1ns/10ps
module mdf_filter_assertions
  import mdf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire mdf_byte_t rx_byte,
  input wire mdf_byte_t acc_byte,
  input wire logic acc_start,
  input wire logic tx_req,
  input wire logic tx_ready,
  input wire logic radio_key
);
  default clocking cb_d @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_key_on;
    $rose(radio_key);
  endsequence
  property p_wr_resp;
    s_wr_both |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response not two cycles after request");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_b_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_block: assert property (p_b_block)
    else $error("new write accepted during response");
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_resp: assert property (p_rd_resp)
    else $error("read answer not one cycle after request");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data changed while pending");
  property p_start_pulse;
    acc_start |=> !acc_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("selection strobe longer than one cycle");
  property p_byte_follows;
    acc_byte.valid |-> $past(rx_byte.valid)
      && acc_byte.data == $past(rx_byte.data);
  endproperty
  a_byte_follows: assert property (p_byte_follows)
    else $error("forwarded byte without matching input");
  property p_ready_req;
    tx_ready |-> $past(tx_req);
  endproperty
  a_ready_req: assert property (p_ready_req)
    else $error("send permission without a request");
  property p_key_first;
    s_key_on |-> $past(tx_req) && !tx_ready;
  endproperty
  a_key_first: assert property (p_key_first)
    else $error("radio keyed late or without request");
endmodule : mdf_filter_assertions

//--- sim/mdf_host.sv
// Far-side master model: serial line and received-byte strobe
`timescale 1ns/10ps
module mdf_host
  import mdf_pkg::*;
#(
  parameter int BIT_CYCLES = 4
) (
  input wire logic aclk,
  output logic rx_pin,
  output mdf_byte_t rx_byte
);
  initial begin
    rx_pin = 1'b1;
    rx_byte = '0;
  end
  // Line rests at mark; only this master opens an exchange
  task automatic hold_line(input logic lvl, input int n);
    rx_pin <= lvl;
    repeat (n) @(posedge aclk);
  endtask : hold_line
  task automatic send_byte(input logic [7:0] b);
    hold_line(1'b0, BIT_CYCLES);
    for (int i = 0; i < 8; i++) begin
      hold_line(b[i], BIT_CYCLES);
    end
    // Byte is flagged as the stop bit starts, so results settle in time
    rx_pin <= 1'b1;
    rx_byte <= {1'b1, b};
    @(posedge aclk);
    // Stale data inverted so a leftover byte is never mistaken
    rx_byte <= {1'b0, ~b};
    repeat (BIT_CYCLES) @(posedge aclk);
  endtask : send_byte
endmodule : mdf_host

//--- sim/tb_top.sv
// Self-checking bench for the multidrop address filter
`timescale 1ns/10ps
module tb_top
  import mdf_pkg::*;
;
  logic aclk, aresetn, awv, wv, bready, arv, rready, tx_req, rx_pin;
  logic awready, wready, bvalid, arready, rvalid, acc_start, acc_bcast;
  logic tx_ready, radio_key;
  logic [7:0] awaddr, araddr, last_b;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [16:0] eff_timeout;
  mdf_byte_t rx_byte, acc_byte;
  int mismatches, n_compared, cyc, n_start, n_byte;
  mdf_filter #(.BIT_CYCLES(4), .IDLE_BITS(3), .BREAK_BITS(12)) mdf_filter_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rx_pin(rx_pin), .rx_byte(rx_byte),
    .acc_byte(acc_byte), .acc_start(acc_start), .acc_bcast(acc_bcast),
    .tx_req(tx_req), .tx_ready(tx_ready), .radio_key(radio_key),
    .eff_timeout(eff_timeout));
  mdf_host #(.BIT_CYCLES(4)) mdf_host_i (
    .aclk(aclk), .rx_pin(rx_pin), .rx_byte(rx_byte));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Sampled at the falling edge, clear of updates on the rising edge
  always @(negedge aclk) begin
    cyc++;
    if (acc_start === 1'b1) n_start++;
    if (acc_byte.valid === 1'b1) begin
      n_byte++;
      last_b = acc_byte.data;
    end
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er, input logic [3:0] s = 4'hf);
    logic aw_t, w_t, b_t;
    logic [1:0] rsp;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = awv && awready;
      w_t = wv && wready;
      b_t = bvalid && bready;
      rsp = bresp;
      @(posedge aclk);
      awv <= awv && !aw_t;
      wv <= wv && !w_t;
    end
    bready <= !b_t;
    // One idle edge so the next call never re-raises bready at once
    @(posedge aclk);
    chk({30'h0, rsp}, {30'h0, er});
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    logic ar_t, r_t;
    logic [31:0] d;
    logic [1:0] rsp;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge aclk);
      ar_t = arv && arready;
      r_t = rvalid && rready;
      d = rdata;
      rsp = rresp;
      @(posedge aclk);
      arv <= arv && !ar_t;
    end
    rready <= !r_t;
    @(posedge aclk);
    chk(d, exp);
    chk({30'h0, rsp}, {30'h0, er});
  endtask : axi_rd
  // Settings only change with the enable cleared
  task automatic cfg(input logic [31:0] c, input logic [7:0] id,
                     input logic [15:0] k);
    axi_wr(OFF_CTRL, 32'h0, RESP_OKAY);
    axi_wr(OFF_OWN_ID, {24'h0, id}, RESP_OKAY);
    axi_wr(OFF_KEY_DLY, {16'h0, k}, RESP_OKAY);
    axi_wr(OFF_CTRL, c, RESP_OKAY);
    mdf_host_i.hold_line(1'b1, 24);
    n_start = 0;
    n_byte = 0;
  endtask : cfg
  task automatic tx_try(input logic e);
    tx_req <= 1'b1;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk({31'h0, tx_ready}, {31'h0, e});
    @(posedge aclk);
    tx_req <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : tx_try
  task automatic t_reset;
    axi_rd(OFF_CTRL, 32'h0, RESP_OKAY);
    axi_rd(OFF_OWN_ID, {24'h0, RST_OWN_ID}, RESP_OKAY);
    axi_rd(OFF_TMO_BASE, {16'h0, RST_TMO_BASE}, RESP_OKAY);
    axi_rd(OFF_EFF_TMO, 32'h0000_0100, RESP_OKAY);
    axi_rd(8'h18, 32'h0, RESP_SLVERR);
    axi_wr(8'h18, 32'h0000_00ff, RESP_SLVERR);
    axi_wr(OFF_KEY_DLY, 32'h0000_ab12, RESP_OKAY, 4'h2);
    axi_rd(OFF_KEY_DLY, 32'h0000_ab00, RESP_OKAY);
    tx_try(1'b0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_station;
    cfg(32'h0000_0021, 8'h21, 16'h0);
    axi_rd(OFF_STATUS, 32'h0000_0021, RESP_OKAY);
    axi_wr(OFF_OWN_ID, 32'h0000_0033, RESP_OKAY);
    axi_rd(OFF_OWN_ID, 32'h0000_0021, RESP_OKAY);
    mdf_host_i.send_byte(8'h22);
    mdf_host_i.send_byte(8'h21);
    chk(32'(n_start + n_byte), 32'h0);
    mdf_host_i.hold_line(1'b1, 24);
    mdf_host_i.send_byte(8'h21);
    chk(32'(n_start), 32'h1);
    tx_try(1'b1);
    mdf_host_i.send_byte(8'h66);
    chk({24'h0, last_b}, 32'h0000_0066);
    mdf_host_i.hold_line(1'b1, 24);
    mdf_host_i.send_byte(BCAST_ADDR);
    chk({31'h0, acc_bcast}, 32'h1);
    tx_try(1'b0);
    mdf_host_i.send_byte(8'h77);
    chk(32'(n_byte), 32'h2);
    $display("station test done");
  endtask : t_station
  task automatic t_enquiry;
    cfg(32'h0000_0011, 8'h42, 16'h0);
    mdf_host_i.send_byte(ENQ_MARK);
    mdf_host_i.send_byte(8'h43);
    mdf_host_i.hold_line(1'b1, 24);
    chk(32'(n_start), 32'h0);
    mdf_host_i.send_byte(ENQ_MARK);
    mdf_host_i.send_byte(8'h42);
    mdf_host_i.send_byte(8'h99);
    chk(32'(n_start), 32'h1);
    chk({24'h0, last_b}, 32'h0000_0099);
    $display("enquiry test done");
  endtask : t_enquiry
  task automatic t_break;
    cfg(32'h0000_0001, 8'h07, 16'h0);
    mdf_host_i.send_byte(8'h07);
    chk(32'(n_start), 32'h0);
    for (int i = 0; i < 2; i++) begin
      mdf_host_i.hold_line(1'b1, 24);
      mdf_host_i.hold_line(1'b0, 60);
      mdf_host_i.hold_line(1'b1, 4);
      mdf_host_i.send_byte(i ? 8'h07 : 8'h08);
      chk(32'(n_start), 32'(i));
    end
    $display("break test done");
  endtask : t_break
  task automatic t_radio;
    int k, r;
    for (int kd = 0; kd < 4; kd += 3) begin
      cfg(32'h0000_000b, 8'h01, 16'(kd));
      chk({15'h0, eff_timeout}, 32'(256 + kd));
      tx_req <= 1'b1;
      k = 0;
      r = 0;
      for (int c = 1; c < 40 && r == 0; c++) begin
        @(negedge aclk);
        if (radio_key === 1'b1 && k == 0) k = c;
        if (tx_ready === 1'b1) r = c;
      end
      chk(32'(r - k), 32'(kd + 1));
      @(posedge aclk);
      tx_req <= 1'b0;
      repeat (3) @(posedge aclk);
      chk({31'h0, radio_key}, 32'h0);
    end
    $display("radio test done");
  endtask : t_radio
  task automatic t_peer;
    cfg(32'h0000_0005, 8'h01, 16'h0);
    tx_try(1'b1);
    cfg(32'h0000_0003, 8'h01, 16'h0);
    tx_try(1'b1);
    $display("peer test done");
  endtask : t_peer
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  initial begin
    aresetn = 1'b0;
    awv = 1'b0;
    wv = 1'b0;
    bready = 1'b0;
    arv = 1'b0;
    rready = 1'b0;
    tx_req = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_station();
    t_enquiry();
    t_break();
    t_radio();
    t_peer();
    end_sim();
  end
endmodule : tb_top
bind mdf_filter mdf_filter_assertions chk_i (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .rx_byte(rx_byte), .acc_byte(acc_byte), .acc_start(acc_start),
  .tx_req(tx_req), .tx_ready(tx_ready), .radio_key(radio_key));
